/* isp_ctrl.sv */
// Interrupt lifecycle, priority and acknowledge logic behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each interrupt keeps its own lifecycle state
// - Peripheral pending from line or set-pending write
// - Soft clear write drops soft interrupt pending
// - Level pending follows its line going low
// - Clear-pending write drops latched pending state
// - Acknowledge read activates best interrupt, returns id
// - Coinciding soft set and acknowledge give both
// - Queued soft copies stay pending after acknowledge
// - Level acknowledge with line high stays pending
// - Edge coinciding with acknowledge keeps pending, else later
// - End (outside split mode), deactivate or linked deactivation clear active
// - Identifiers 1020 to 1023 never name sources
// - No signalable interrupt: acknowledge returns 1023
// - Priority keeps upper bits, low bits zero
// - Lower priority value wins, zero highest
// - Per-interrupt priority, optionally fixed read-only
// - Priority writes apply at once, even active
// - Writing all ones reveals implemented priority bits
// - Signal only below mask and running priority
// - Acknowledge preempts; earlier interrupt stays active
// - Dropped priority leaves running priority; split mode
// - Active interrupts are never signaled again
// - Mask resets to zero, blocking everything
module isp_ctrl import isp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire isp_axi_req_s bus_req,
  output var isp_axi_rsp_s bus_rsp,
  input wire logic [NUM_PERI-1:0] irq_line,
  input wire isp_deact_s phys_deact,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  isp_state_s s;
  isp_state_s next_s;

  logic [NUM_ID-1:0] pend;
  logic [NUM_ID-1:0] elig;
  logic [PRIO_W-1:0] run_prio;
  logic [PRIO_W-1:0] best_prio;
  logic [IDX_W-1:0] best;
  logic sig_any;
  logic aw_rdy;
  logic w_rdy;
  logic wr_fire;
  logic rd_fire;
  logic ack_fire;

  assign aw_rdy = !s.aw_ok && !s.bvalid;
  assign w_rdy = !s.w_ok && !s.bvalid;
  assign wr_fire = s.aw_ok && s.w_ok && !s.bvalid;
  assign rd_fire = bus_req.arvalid && !s.rvalid;
  assign ack_fire = rd_fire && (bus_req.araddr == OFF_ACK);

  assign bus_rsp.awready = aw_rdy;
  assign bus_rsp.wready = w_rdy;
  assign bus_rsp.bvalid = s.bvalid;
  assign bus_rsp.bresp = s.bresp;
  assign bus_rsp.arready = !s.rvalid;
  assign bus_rsp.rvalid = s.rvalid;
  assign bus_rsp.rdata = s.rdata;
  assign bus_rsp.rresp = s.rresp;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Pending, running priority and selection
  // ----------------------------------------------------------------
  always_comb begin
    run_prio = PRIO_IDLE;
    for (int i = 0; i < NUM_ID; i++) begin
      if (s.held[i] && s.prio[i] < run_prio) begin
        run_prio = s.prio[i];
      end
    end
    for (int i = 0; i < NUM_SOFT; i++) begin
      pend[i] = s.soft_cnt[i] != '0;
    end
    for (int j = 0; j < NUM_PERI; j++) begin
      pend[NUM_SOFT+j] = s.latch[j] | (~s.edge_mode[j] & s.line_s[j]);
    end
    best = '0;
    best_prio = PRIO_IDLE;
    sig_any = 1'b0;
    for (int i = NUM_ID - 1; i >= 0; i--) begin
      // Lower value is more urgent; mask and running priority gate
      elig[i] = pend[i] & s.enable[i] & ~s.active[i]
        & (s.prio[i] < s.pmask) & (s.prio[i] < run_prio);
      if (elig[i] && (!sig_any || s.prio[i] <= best_prio)) begin
        best = IDX_W'(i);
        best_prio = s.prio[i];
        sig_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [ID_W-1:0] did;
    logic [IDX_W-1:0] didx;
    logic [IDX_W-1:0] pidx;
    logic [IDX_W-1:0] base;
    logic [DATA_W-1:0] rd;
    did = '0;
    didx = '0;
    pidx = '0;
    base = '0;
    rd = '0;
    next_s = s;

    // Bus intake and response retirement
    if (bus_req.awvalid && aw_rdy) begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = bus_req.awaddr;
    end
    if (bus_req.wvalid && w_rdy) begin
      next_s.w_ok = 1'b1;
      next_s.wdata = bus_req.wdata;
      next_s.wstrb = bus_req.wstrb;
    end
    if (s.bvalid && bus_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && bus_req.rready) begin
      next_s.rvalid = 1'b0;
    end

    // Request line synchroniser
    next_s.line_m = irq_line;
    next_s.line_s = s.line_m;
    next_s.line_p = s.line_s;

    // Register writes; clears come before sets
    if (wr_fire) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      did = s.wdata[ID_W-1:0];
      didx = s.wdata[IDX_W-1:0];
      base = (s.awaddr == OFF_PRIO1) ? IDX_W'(IDS_PER_WORD) : '0;
      case (s.awaddr)
        OFF_ENABLE: next_s.enable = s.wdata[NUM_ID-1:0];
        OFF_CLRPEND: next_s.latch = s.latch & ~s.wdata[NUM_ID-1:NUM_SOFT];
        OFF_SOFTCLR: begin
          for (int k = 0; k < NUM_SOFT; k++) begin
            if (s.wdata[k]) begin
              next_s.soft_cnt[k] = '0;
            end
          end
        end
        OFF_CFG: next_s.edge_mode = s.wdata[NUM_ID-1:NUM_SOFT];
        OFF_PRIO0, OFF_PRIO1: begin
          for (int b = 0; b < IDS_PER_WORD; b++) begin
            pidx = base + IDX_W'(b);
            if (s.wstrb[b] && !PRIO_RO[pidx]) begin
              // Applies at once, active or not; low bits drop
              next_s.prio[pidx] = s.wdata[8*b +: 8] & PRIO_KEEP;
            end
          end
        end
        OFF_PMASK: next_s.pmask = s.wdata[PRIO_W-1:0] & PRIO_KEEP;
        OFF_EOI: begin
          if (did < ID_W'(NUM_ID)) begin
            next_s.held[didx] = 1'b0;
            if (!s.split) begin
              next_s.active[didx] = 1'b0;
            end
          end
        end
        OFF_DIR: begin
          if (did < ID_W'(NUM_ID)) begin
            next_s.active[didx] = 1'b0;
            next_s.held[didx] = 1'b0;
          end
        end
        OFF_CTRL: next_s.split = s.wdata[0];
        OFF_SETPEND, OFF_ACTIVE, OFF_ACK, OFF_RUNPRIO, OFF_HIPEND: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // Linked deactivation from a virtual interface
    if (phys_deact.valid && phys_deact.id < ID_W'(NUM_ID)) begin
      next_s.active[phys_deact.id[IDX_W-1:0]] = 1'b0;
      next_s.held[phys_deact.id[IDX_W-1:0]] = 1'b0;
    end

    // Register reads and acknowledge
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      base = (bus_req.araddr == OFF_PRIO1) ? IDX_W'(IDS_PER_WORD) : '0;
      case (bus_req.araddr)
        OFF_ENABLE: rd[NUM_ID-1:0] = s.enable;
        OFF_SETPEND, OFF_CLRPEND: rd[NUM_ID-1:0] = pend;
        OFF_SOFTCLR: rd[NUM_SOFT-1:0] = pend[NUM_SOFT-1:0];
        OFF_CFG: rd[NUM_ID-1:NUM_SOFT] = s.edge_mode;
        OFF_ACTIVE: rd[NUM_ID-1:0] = s.active;
        OFF_PRIO0, OFF_PRIO1: begin
          for (int b = 0; b < IDS_PER_WORD; b++) begin
            pidx = base + IDX_W'(b);
            rd[8*b +: 8] = PRIO_RO[pidx] ? PRIO_RO_VAL : s.prio[pidx];
          end
        end
        OFF_PMASK: rd[PRIO_W-1:0] = s.pmask;
        OFF_ACK: begin
          rd[ID_W-1:0] = sig_any ? ID_W'(best) : ID_SPURIOUS;
          if (sig_any) begin
            // Earlier active interrupts stay active underneath
            next_s.active[best] = 1'b1;
            next_s.held[best] = 1'b1;
            if (best < IDX_W'(NUM_SOFT)) begin
              // One queued copy consumed; the rest stay pending
              next_s.soft_cnt[best[SOFT_IDX_W-1:0]] =
                s.soft_cnt[best[SOFT_IDX_W-1:0]] - SOFT_CNT_W'(1);
            end else begin
              pidx = best - IDX_W'(NUM_SOFT);
              // Level line still high keeps pending via the line
              next_s.latch[pidx[PERI_IDX_W-1:0]] = 1'b0;
            end
          end
        end
        OFF_EOI, OFF_DIR: rd = '0;
        OFF_RUNPRIO: rd[PRIO_W-1:0] = run_prio;
        OFF_HIPEND: rd[ID_W-1:0] = sig_any ? ID_W'(best) : ID_SPURIOUS;
        OFF_CTRL: rd[0] = s.split;
        default: next_s.rresp = RESP_SLVERR;
      endcase
      next_s.rdata = rd;
    end

    // Sets last, so they win over any clear in the same cycle
    for (int j = 0; j < NUM_PERI; j++) begin
      if (s.edge_mode[j] && s.line_s[j] && !s.line_p[j]) begin
        next_s.latch[j] = 1'b1;
      end
      if (wr_fire && s.awaddr == OFF_SETPEND && s.wdata[NUM_SOFT+j]) begin
        next_s.latch[j] = 1'b1;
      end
    end
    for (int k = 0; k < NUM_SOFT; k++) begin
      if (wr_fire && s.awaddr == OFF_SETPEND && s.wdata[k]
          && next_s.soft_cnt[k] != SOFT_CNT_MAX) begin
        next_s.soft_cnt[k] = next_s.soft_cnt[k] + SOFT_CNT_W'(1);
      end
    end

    next_s.irq = sig_any;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    s.pmask == '0 |=> !s.irq)
    else $error("interrupt raised while mask is zero");

  chk_spurious_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire && !sig_any |=> s.rvalid && s.rdata == DATA_W'(ID_SPURIOUS))
    else $error("acknowledge without candidate did not return spurious id");

  chk_ack_activates: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire && sig_any |=> s.active[$past(best)] && s.rdata == DATA_W'($past(best)))
    else $error("acknowledge did not activate or return the chosen id");

  chk_no_resignal: assert property (@(posedge aclk) disable iff (!aresetn)
    sig_any |-> !s.active[best] && s.enable[best] && pend[best])
    else $error("active or disabled interrupt offered");

  chk_signal_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    sig_any |-> s.prio[best] < s.pmask && s.prio[best] < run_prio)
    else $error("offered interrupt not above mask and running priority");

  chk_prio_lowbits: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.prio[best] & ~PRIO_KEEP) == '0 && (s.pmask & ~PRIO_KEEP) == '0)
    else $error("unimplemented priority bits are set");

  chk_soft_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_SOFTCLR && s.wdata[0] |=> s.soft_cnt[0] == '0)
    else $error("soft interrupt still pending after clear");

  chk_eoi_deact: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_EOI && !s.split && s.wdata[ID_W-1:0] < ID_W'(NUM_ID)
    |=> !s.active[$past(s.wdata[IDX_W-1:0])] && s.bvalid)
    else $error("end of interrupt left the interrupt active");

  chk_dir_deact: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_DIR && s.wdata[ID_W-1:0] < ID_W'(NUM_ID) && !ack_fire
    |=> !s.active[$past(s.wdata[IDX_W-1:0])])
    else $error("deactivate write left the interrupt active");

  chk_link_deact: assert property (@(posedge aclk) disable iff (!aresetn)
    phys_deact.valid && phys_deact.id < ID_W'(NUM_ID) && !ack_fire
    |=> !s.active[$past(phys_deact.id[IDX_W-1:0])])
    else $error("linked deactivation left the interrupt active");

  chk_split_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_EOI && s.split && s.wdata[ID_W-1:0] < ID_W'(NUM_ID)
    && !ack_fire && !phys_deact.valid
    |=> !s.held[$past(s.wdata[IDX_W-1:0])] && s.active == $past(s.active))
    else $error("split end of interrupt did not only drop priority");

  chk_run_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    s.held == '0 |-> run_prio == PRIO_IDLE)
    else $error("running priority set with nothing held");

  chk_clrpend_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_CLRPEND && s.wdata[NUM_SOFT]
    && !(s.edge_mode[0] && s.line_s[0] && !s.line_p[0]) |=> !s.latch[0])
    else $error("clear pending left the latch set");

  chk_setpend_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_SETPEND && s.wdata[NUM_SOFT] |=> s.latch[0])
    else $error("set pending did not latch");

  chk_edge_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    s.edge_mode[0] && s.line_s[0] && !s.line_p[0] |=> s.latch[0])
    else $error("rising edge did not latch pending");

  chk_level_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    !s.edge_mode[0] && !s.latch[0] && !s.line_s[0] |-> !pend[NUM_SOFT])
    else $error("level interrupt pending with line low");

  chk_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire && sig_any && best == IDX_W'(NUM_SOFT) && !s.edge_mode[0]
    && s.line_s[0] && s.line_m[0] |=> pend[NUM_SOFT] && s.active[NUM_SOFT])
    else $error("level acknowledge with line high not active and pending");

  chk_soft_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_SETPEND && s.wdata[0] |=> s.soft_cnt[0] != '0)
    else $error("soft set pending lost");

  chk_soft_queue: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire && sig_any && best == '0 && !wr_fire && s.soft_cnt[0] > SOFT_CNT_W'(1)
    |=> s.active[0] && s.soft_cnt[0] != '0)
    else $error("queued soft copy not left pending");

  chk_tie_lowest: assert property (@(posedge aclk) disable iff (!aresetn)
    sig_any && best != '0 |-> !(elig[0] && s.prio[0] <= best_prio))
    else $error("priority tie not resolved to lowest id");

  chk_best_urgent: assert property (@(posedge aclk) disable iff (!aresetn)
    sig_any && elig[0] |-> best_prio <= s.prio[0])
    else $error("chosen interrupt less urgent than a candidate");

  chk_prio_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_PRIO0 && s.wstrb[0] && !PRIO_RO[0]
    |=> s.prio[0] == ($past(s.wdata[PRIO_W-1:0]) & PRIO_KEEP))
    else $error("priority write not stored as implemented bits");

  chk_reserved_id: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire |=> s.rdata[ID_W-1:0] < ID_W'(NUM_ID) || s.rdata[ID_W-1:0] == ID_SPURIOUS)
    else $error("acknowledge returned a reserved id");

  chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> s.irq == $past(sig_any))
    else $error("interrupt request does not follow selection");

  chk_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s.pmask == '0 |-> !sig_any)
    else $error("interrupt selected while mask is zero");

  chk_active_stay: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_fire && sig_any && !wr_fire && !phys_deact.valid
    |=> (s.active & $past(s.active)) == $past(s.active))
    else $error("preemption cleared an earlier active interrupt");

endmodule

`default_nettype wire

/* isp_ctrl_tb_top.sv */
// Self-checking testbench of the interrupt state and priority block
`timescale 1ns/1ps
`default_nettype none
module isp_ctrl_tb_top import isp_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  isp_axi_req_s req = '{bready: 1'b1, rready: 1'b1, default: '0};
  isp_axi_rsp_s rsp;
  isp_deact_s pd = '0;
  logic [NUM_PERI-1:0] lvl = '0;
  logic [NUM_PERI-1:0] pls = '0;
  logic [NUM_PERI-1:0] line;
  logic irq;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int cnt[4];
  int op;
  int k;
  logic [7:0] act;
  logic [7:0] pr[4];
  logic [31:0] rv;
  logic [31:0] d;
  logic [1:0] rr;
  logic [1:0] br;

  always #2.5 aclk = ~aclk;

  isp_ctrl dut (.aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp),
    .irq_line(line), .phys_deact(pd), .irq(irq));
  isp_periph peri (.aclk(aclk), .aresetn(aresetn), .level(lvl), .pulse(pls),
    .irq_line(line));

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    forever begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        br = rsp.bresp;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    forever begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rv = rsp.rdata;
        rr = rsp.rresp;
        break;
      end
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    chk(rv, x);
  endtask

  task automatic pulse6();
    pls <= 4'h4;
    @(posedge aclk);
    pls <= 4'h0;
    repeat (5) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Reference model of the soft interrupts
  // ----------------------------------------------------------------
  function automatic logic [7:0] runp();
    logic [7:0] m;
    m = 8'hFF;
    for (int i = 0; i < 4; i++) if (act[i] && pr[i] < m) m = pr[i];
    return m;
  endfunction

  function automatic logic [ID_W-1:0] best();
    logic [7:0] b;
    logic [ID_W-1:0] id;
    b = (runp() < 8'hF0) ? runp() : 8'hF0;
    id = ID_SPURIOUS;
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] > 0 && !act[i] && pr[i] < b) begin
        b = pr[i];
        id = ID_W'(i);
      end
    end
    return id;
  endfunction

  function automatic logic [31:0] pend();
    logic [31:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) p[i] = cnt[i] > 0;
    return p;
  endfunction

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hA04179F8));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFF_PMASK, 32'h0);
    wr(OFF_PRIO0, 32'hFFFFFFFF);
    rc(OFF_PRIO0, {4{PRIO_KEEP}});
    wr(OFF_ENABLE, 32'h01);
    wr(OFF_PRIO0, 32'h0);
    wr(OFF_SETPEND, 32'h01);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rc(OFF_ACK, 32'h3FF);
    wr(OFF_SOFTCLR, 32'h01);
    rc(OFF_SETPEND, 32'h0);
    rd(8'h3C);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(8'h3C, 32'h1);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    wr(OFF_PRIO1, 32'h30201000);
    wr(OFF_CFG, 32'hC0);
    wr(OFF_ENABLE, 32'hF0);
    wr(OFF_PMASK, 32'hFF);
    rc(OFF_PMASK, 32'hF0);
    lvl <= 4'h1;
    repeat (4) @(posedge aclk);
    rc(OFF_SETPEND, 32'h10);
    rc(OFF_ACK, 32'h4);
    rc(OFF_SETPEND, 32'h10);
    lvl <= 4'h0;
    repeat (4) @(posedge aclk);
    rc(OFF_SETPEND, 32'h0);
    wr(OFF_EOI, 32'h4);
    rc(OFF_ACTIVE, 32'h0);
    wr(OFF_SETPEND, 32'h20);
    rc(OFF_SETPEND, 32'h20);
    wr(OFF_CLRPEND, 32'h20);
    rc(OFF_SETPEND, 32'h0);
    pulse6();
    rc(OFF_SETPEND, 32'h40);
    wr(OFF_CLRPEND, 32'h40);
    rc(OFF_SETPEND, 32'h0);
    pulse6();
    wr(OFF_CTRL, 32'h1);
    rc(OFF_ACK, 32'h6);
    rc(OFF_SETPEND, 32'h0);
    pulse6();
    rc(OFF_SETPEND, 32'h40);
    wr(OFF_SETPEND, 32'h10);
    rc(OFF_ACK, 32'h4);
    rc(OFF_ACTIVE, 32'h50);
    wr(OFF_EOI, 32'h4);
    rc(OFF_ACTIVE, 32'h50);
    rc(OFF_RUNPRIO, 32'h20);
    wr(OFF_DIR, 32'h4);
    rc(OFF_ACTIVE, 32'h40);
    wr(OFF_EOI, 32'h6);
    rc(OFF_RUNPRIO, 32'hFF);
    rc(OFF_HIPEND, 32'h3FF);
    wr(OFF_DIR, 32'h6);
    rc(OFF_ACK, 32'h6);
    pd <= '{valid: 1'b1, id: 10'h6};
    @(posedge aclk);
    pd.valid <= 1'b0;
    repeat (2) @(posedge aclk);
    rc(OFF_ACTIVE, 32'h0);
    wr(OFF_EOI, 32'h6);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_ENABLE, 32'h0F);
    wr(OFF_PMASK, 32'hF0);
    act = '0;
    for (k = 0; k < 4; k++) begin
      cnt[k] = 0;
      pr[k] = 8'h0;
    end
    repeat (80) begin
      op = $urandom_range(3);
      case (op)
        0: begin
          d = 32'($urandom_range(15));
          wr(OFF_SETPEND, d);
          for (k = 0; k < 4; k++) if (d[k] && cnt[k] < 3) cnt[k]++;
        end
        1: begin
          rc(OFF_ACK, {22'h0, best()});
          if (best() != ID_SPURIOUS) begin
            k = int'(best());
            act[k] = 1'b1;
            cnt[k]--;
          end
        end
        2: begin
          k = $urandom_range(3);
          wr(OFF_EOI, 32'(k));
          act[k] = 1'b0;
        end
        default: begin
          d = $urandom;
          wr(OFF_PRIO0, d);
          for (k = 0; k < 4; k++) pr[k] = d[8*k +: 8] & PRIO_KEEP;
        end
      endcase
      rc(OFF_HIPEND, {22'h0, best()});
      rc(OFF_SETPEND, pend());
      rc(OFF_ACTIVE, {24'h0, act});
      rc(OFF_RUNPRIO, {24'h0, runp()});
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, best() != ID_SPURIOUS});
    end
    end_sim();
  end
endmodule
`default_nettype wire

/* isp_periph.sv */
// Peripheral request line model for the interrupt state and priority block
`timescale 1ns/1ps
`default_nettype none
module isp_periph import isp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_PERI-1:0] level,
  input wire logic [NUM_PERI-1:0] pulse,
  output logic [NUM_PERI-1:0] irq_line
);
  logic [NUM_PERI-1:0] pulse_d;

  // ----------------------------------------------------------------
  // Lines: held levels plus two-cycle edge pulses
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_d <= '0;
      irq_line <= '0;
    end else begin
      pulse_d <= pulse;
      irq_line <= level | pulse | pulse_d;
    end
  end
endmodule
`default_nettype wire

/* isp_pkg.sv */
// Constants, register map and carrier types of the interrupt state and priority block
package isp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_ID = 8;
  localparam int NUM_SOFT = 4;
  localparam int NUM_PERI = 4;
  localparam int IDX_W = 3;
  localparam int SOFT_IDX_W = 2;
  localparam int PERI_IDX_W = 2;
  localparam int ID_W = 10;
  localparam int PRIO_W = 8;
  localparam int PRIO_IMPL = 4;
  localparam int SOFT_CNT_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IDS_PER_WORD = 4;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_KEEP = 8'(8'hFF << (PRIO_W - PRIO_IMPL));
  localparam logic [PRIO_W-1:0] PRIO_IDLE = 8'hFF;
  localparam logic [NUM_ID-1:0] PRIO_RO = 8'h00;
  localparam logic [PRIO_W-1:0] PRIO_RO_VAL = 8'h00;
  localparam logic [ID_W-1:0] ID_RSV_LO = 10'h3FC;
  localparam logic [ID_W-1:0] ID_SPURIOUS = 10'h3FF;
  localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_MAX = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SETPEND = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CLRPEND = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SOFTCLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PRIO0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PRIO1 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PMASK = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ACK = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_EOI = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_DIR = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_RUNPRIO = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_HIPEND = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h38;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } isp_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } isp_axi_rsp_s;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
  } isp_deact_s;

  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [NUM_PERI-1:0] line_m;
    logic [NUM_PERI-1:0] line_s;
    logic [NUM_PERI-1:0] line_p;
    logic [NUM_PERI-1:0] latch;
    logic [NUM_PERI-1:0] edge_mode;
    logic [NUM_ID-1:0] enable;
    logic [NUM_ID-1:0] active;
    logic [NUM_ID-1:0] held;
    logic [NUM_SOFT-1:0][SOFT_CNT_W-1:0] soft_cnt;
    logic [NUM_ID-1:0][PRIO_W-1:0] prio;
    logic [PRIO_W-1:0] pmask;
    logic split;
    logic irq;
  } isp_state_s;

endpackage
